// >>> verilog/slt_link_regs.vh
// constants for the serial link transmit control and receive framer
// assumes a 20 MHz core clock that also stands in for the bit clock
`ifndef SLT_LINK_REGS_VH
`define SLT_LINK_REGS_VH

// wishbone register byte offsets
`define SLT_OFS_CTRL 8'h00
`define SLT_OFS_STATUS 8'h04
`define SLT_OFS_RXCHAR 8'h08

// control register fields
`define SLT_CTRL_SPEED 0
`define SLT_CTRL_RANGE 1
`define SLT_CTRL_FIFO_BYP_N 2
`define SLT_CTRL_ENC_BYP_N 3
`define SLT_CTRL_WIDTH 4
`define SLT_CTRL_LOOPBACK 5
`define SLT_CTRL_PORT_B 6
`define SLT_CTRL_REFRAME 7
`define SLT_CTRL_WIDTH_BITS 8
`define SLT_CTRL_RESET 8'h9c

// status register fields
`define SLT_STAT_FAULT 0
`define SLT_STAT_ON_REF 1
`define SLT_STAT_FRAMED 2
`define SLT_STAT_EFF_RANGE 3
`define SLT_STAT_MULT_LSB 4

// bit clock multiplier codes (x2.5, x5, x10 of reference)
`define SLT_MULT_X2P5 2'h0
`define SLT_MULT_X5 2'h1
`define SLT_MULT_X10 2'h2

// character lengths in bits, minus one, and half lengths
`define SLT_LEN_NARROW_M1 4'h9
`define SLT_LEN_WIDE_M1 4'hb
`define SLT_HALF_NARROW 4'h5
`define SLT_HALF_WIDE 4'h6

// sync fill characters, first bit sent in bit 0
`define SLT_SYNC_SHORT 10'h238
`define SLT_SYNC_LONG 12'hc71

`endif

// >>> verilog/slt_symbol_codec.v
// block code encoder and decoder for one character
// assumes a 4b/5b nibble code, widened to 5b/6b for 12-bit characters
`timescale 1ns/10ps
`default_nettype none
`include "slt_link_regs.vh"

module slt_symbol_codec (
  input wire wide_i,
  input wire [9:0] enc_word_i,
  input wire [11:0] dec_char_i,
  output reg [11:0] enc_char_o,
  output reg [9:0] dec_word_o,
  output reg dec_cmd_o,
  output reg dec_bad_o
);

  // nibble to five-bit symbol
  function [4:0] enc5;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc5 = 5'h1e;
        4'h1: enc5 = 5'h09;
        4'h2: enc5 = 5'h14;
        4'h3: enc5 = 5'h15;
        4'h4: enc5 = 5'h0a;
        4'h5: enc5 = 5'h0b;
        4'h6: enc5 = 5'h0e;
        4'h7: enc5 = 5'h0f;
        4'h8: enc5 = 5'h12;
        4'h9: enc5 = 5'h13;
        4'ha: enc5 = 5'h16;
        4'hb: enc5 = 5'h17;
        4'hc: enc5 = 5'h1a;
        4'hd: enc5 = 5'h1b;
        4'he: enc5 = 5'h1c;
        default: enc5 = 5'h1d;
      endcase
    end
  endfunction

  // five-bit symbol to {invalid, nibble}
  function [4:0] dec5;
    input [4:0] s;
    begin
      case (s)
        5'h1e: dec5 = 5'h00;
        5'h09: dec5 = 5'h01;
        5'h14: dec5 = 5'h02;
        5'h15: dec5 = 5'h03;
        5'h0a: dec5 = 5'h04;
        5'h0b: dec5 = 5'h05;
        5'h0e: dec5 = 5'h06;
        5'h0f: dec5 = 5'h07;
        5'h12: dec5 = 5'h08;
        5'h13: dec5 = 5'h09;
        5'h16: dec5 = 5'h0a;
        5'h17: dec5 = 5'h0b;
        5'h1a: dec5 = 5'h0c;
        5'h1b: dec5 = 5'h0d;
        5'h1c: dec5 = 5'h0e;
        5'h1d: dec5 = 5'h0f;
        default: dec5 = 5'h10;
      endcase
    end
  endfunction

  reg [4:0] lo_d;
  reg [4:0] hi_d;

  // encode: two symbols, 6-bit symbols carry a balancing top bit
  always @*
  begin
    if (wide_i)
    begin
      enc_char_o = {~enc_word_i[9], enc_word_i[9:5],
                    ~enc_word_i[4], enc_word_i[4:0]};
    end
    else
    begin
      enc_char_o = {2'h0, enc5(enc_word_i[7:4]), enc5(enc_word_i[3:0])};
    end
  end

  // decode, sync characters report as command code zero
  always @*
  begin
    lo_d = dec5(dec_char_i[4:0]);
    hi_d = dec5(dec_char_i[9:5]);
    dec_cmd_o = 1'b0;
    dec_word_o = 10'h000;
    dec_bad_o = 1'b0;
    if (wide_i)
    begin
      if (dec_char_i == `SLT_SYNC_LONG)
        dec_cmd_o = 1'b1;
      else
      begin
        dec_word_o = {dec_char_i[10:6], dec_char_i[4:0]};
        dec_bad_o = (dec_char_i[11] == dec_char_i[10]) |
                    (dec_char_i[5] == dec_char_i[4]);
      end
    end
    else if (dec_char_i[9:0] == `SLT_SYNC_SHORT)
      dec_cmd_o = 1'b1;
    else
    begin
      dec_word_o = {2'h0, hi_d[3:0], lo_d[3:0]};
      dec_bad_o = lo_d[4] | hi_d[4];
    end
  end

endmodule // slt_symbol_codec

`default_nettype wire

// >>> verilog/slt_link_core.v
// transmit control and receive front path of a serial link transceiver
// assumes one core clock per serial bit, wishbone classic register access,
// and external fifos that show their head word before a read
//
// Behaviour
// - speed and range set the bit clock multiplier
// - slow speed in fifo bypass forces range low
// - bypass: input register feeds the pipeline register
// - no accepted word sends sync command fill
// - encoder and fifo bypassed: raw sync to shifter
// - encoder bypassed, fifo empty: raw sync too
// - halt only obeyed with the fifo enabled
// - halt stops fifo reads at next character
// - receive from port a, port b or loopback
// - link valid needs amplitude, transitions, frequency, carrier
// - fault output changes only at receive character slots
// - clock recovery falls back to reference off-frequency
// - free counter divides bits into characters
// - framer searches every bit offset for sync
// - reframe enable gates boundary realignment
// - realign by shifting position, never the clock
// - decoder gives code and command/data flag
// - invalid or disparity errors raise violation output
// - decoder bypass passes framed character unchanged
// - encoder bypass sends pre-coded characters unmodified
// - shifter sends lsb first as nrzi
`timescale 1ns/10ps
`default_nettype none
`include "slt_link_regs.vh"

module slt_link_core (
  input wire core_clk_i,
  input wire reset_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire transmit_halt_i,
  input wire [11:0] transmit_word_bus_i,
  input wire transmit_word_enable_i,
  input wire transmit_fifo_full_flag_i,
  input wire tx_fifo_empty_i,
  input wire [11:0] tx_fifo_word_i,
  output wire tx_fifo_read_o,
  output wire serial_out_o,
  input wire serial_input_port_a_i,
  input wire serial_input_port_b_i,
  input wire amplitude_ok_i,
  input wire transition_ok_i,
  input wire freq_in_range_i,
  input wire carrier_detect_i,
  output wire link_fault_indicator_o,
  output wire receive_clock_o,
  output reg [11:0] rx_word_o,
  output reg rx_word_valid_o,
  output reg receive_command_data_flag_o,
  output reg violation_output_o
);

  reg [7:0] ctrl_r;
  reg [3:0] tx_cnt_r;
  reg [3:0] rx_cnt_r;
  reg [11:0] in_word_r;
  reg in_valid_r;
  reg [11:0] tx_shift_r;
  reg line_r;
  reg rx_prev_r;
  reg [23:0] rx_shift_r;
  reg [3:0] align_r;
  reg framed_r;
  reg fault_r;
  reg receive_clock_r;
  reg [11:0] tx_char_nxt;
  reg tx_take_fifo;
  reg [1:0] mult_code;
  reg [11:0] rx_char;
  reg [31:0] rd_data;
  reg rx_sel_r;
  reg rx_lb_r;

  wire speed_select = ctrl_r[`SLT_CTRL_SPEED];
  wire range_select = ctrl_r[`SLT_CTRL_RANGE];
  wire fifo_bypass_n = ctrl_r[`SLT_CTRL_FIFO_BYP_N];
  wire encoder_bypass_n = ctrl_r[`SLT_CTRL_ENC_BYP_N];
  wire width_select = ctrl_r[`SLT_CTRL_WIDTH];
  wire loopback_control = ctrl_r[`SLT_CTRL_LOOPBACK];
  wire port_select = ctrl_r[`SLT_CTRL_PORT_B];
  wire reframe_enable = ctrl_r[`SLT_CTRL_REFRAME];

  // 12-bit characters when width select is low
  wire wide = ~width_select;
  wire [3:0] len_m1 = wide ? `SLT_LEN_WIDE_M1 : `SLT_LEN_NARROW_M1;
  wire [3:0] half_len = wide ? `SLT_HALF_WIDE : `SLT_HALF_NARROW;
  wire tx_slot = (tx_cnt_r == len_m1);
  wire rx_slot = (rx_cnt_r == len_m1);

  // range forced low at slow speed with fifos bypassed
  wire eff_range = range_select & ~(~speed_select & ~fifo_bypass_n);

  // bit clock multiplier from speed and effective range
  always @*
  begin
    case ({speed_select, eff_range})
      2'b01: mult_code = `SLT_MULT_X2P5;
      2'b10: mult_code = `SLT_MULT_X10;
      default: mult_code = `SLT_MULT_X5;
    endcase
  end

  // wishbone decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];

  // read mux, unmapped offsets read zero
  always @*
  begin
    case (wb_adr_i)
      `SLT_OFS_CTRL: rd_data = {24'h000000, ctrl_r};
      `SLT_OFS_STATUS: rd_data = {26'h0000000, mult_code, eff_range,
                                  framed_r, ~freq_in_range_i, fault_r};
      `SLT_OFS_RXCHAR: rd_data = {18'h00000, violation_output_o,
                                  receive_command_data_flag_o, rx_word_o};
      default: rd_data = 32'h00000000;
    endcase
  end

  // ack one cycle after request, control register write
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_r <= `SLT_CTRL_RESET;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= rd_data;
      if (wb_wr && wb_adr_i == `SLT_OFS_CTRL)
        ctrl_r <= wb_dat_i[7:0];
    end
  end

  // input register catches each enabled word in fifo bypass while the full flag is low
  wire in_accept = ~fifo_bypass_n & transmit_word_enable_i &
                   ~transmit_fifo_full_flag_i;

  // halt ignored unless the fifo is in use
  wire halt_eff = fifo_bypass_n & transmit_halt_i;

  // fifo read only at a character slot and not halted
  always @*
  begin
    tx_take_fifo = fifo_bypass_n & tx_slot & ~tx_fifo_empty_i & ~halt_eff;
  end
  assign tx_fifo_read_o = tx_take_fifo;

  wire [11:0] tx_word = fifo_bypass_n ? tx_fifo_word_i : in_word_r;
  wire tx_have = fifo_bypass_n ? tx_take_fifo : in_valid_r;
  wire [11:0] enc_char;
  wire [9:0] dec_word;
  wire dec_cmd;
  wire dec_bad;

  slt_symbol_codec u_codec (
    .wide_i(wide),
    .enc_word_i(tx_word[9:0]),
    .dec_char_i(rx_char),
    .enc_char_o(enc_char),
    .dec_word_o(dec_word),
    .dec_cmd_o(dec_cmd),
    .dec_bad_o(dec_bad)
  );

  // choose the character for the next slot
  always @*
  begin
    if (tx_have)
    begin
      if (!encoder_bypass_n)
        tx_char_nxt = wide ? tx_word : {2'h0, tx_word[9:0]};
      else
        tx_char_nxt = enc_char;
    end
    else
    begin
      // sync fill; pattern is the coded command
      tx_char_nxt = wide ? `SLT_SYNC_LONG : {2'h0, `SLT_SYNC_SHORT};
    end
  end

  // transmit slot counter, input register and pipeline shifter
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      tx_cnt_r <= 4'h0;
      in_word_r <= 12'h000;
      in_valid_r <= 1'b0;
      tx_shift_r <= 12'h000;
      line_r <= 1'b0;
    end
    else
    begin
      tx_cnt_r <= tx_slot ? 4'h0 : tx_cnt_r + 4'h1;
      // newest accepted word waits for the slot
      if (in_accept)
      begin
        in_word_r <= transmit_word_bus_i;
        in_valid_r <= 1'b1;
      end
      else if (tx_slot)
        in_valid_r <= 1'b0;
      // lsb first, a one toggles the line
      line_r <= line_r ^ tx_shift_r[0];
      if (tx_slot)
        tx_shift_r <= tx_char_nxt;
      else
        tx_shift_r <= {1'b0, tx_shift_r[11:1]};
    end
  end
  assign serial_out_o = line_r;

  // receive source: loopback, else port a or b
  wire rx_line = loopback_control ? line_r :
                 (port_select ? serial_input_port_b_i : serial_input_port_a_i);

  wire on_ref = ~freq_in_range_i;

  // all four checks for a valid link
  wire link_ok = amplitude_ok_i & transition_ok_i & freq_in_range_i &
                 carrier_detect_i;

  wire sync_hit = wide ? (rx_shift_r[23:12] == `SLT_SYNC_LONG) :
                         (rx_shift_r[23:14] == `SLT_SYNC_SHORT);

  // bits since the found boundary, always below the length
  wire [3:0] delay = (align_r > len_m1) ? 4'h0 : len_m1 - align_r;

  // pick the framed character out of the shift register
  always @*
  begin
    if (wide)
      rx_char = rx_shift_r[(5'd12 - {1'b0, delay}) +: 12];
    else
      rx_char = {2'h0, rx_shift_r[(5'd14 - {1'b0, delay}) +: 10]};
  end

  // receive counter, nrzi decode, framer and decoder output
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rx_cnt_r <= 4'h0;
      rx_prev_r <= 1'b0;
      rx_shift_r <= 24'h000000;
      align_r <= 4'h0;
      framed_r <= 1'b0;
      fault_r <= 1'b1;
      receive_clock_r <= 1'b0;
      rx_word_o <= 12'h000;
      rx_word_valid_o <= 1'b0;
      receive_command_data_flag_o <= 1'b0;
      violation_output_o <= 1'b0;
    end
    else
    begin
      // free running divide by ten or twelve
      rx_cnt_r <= rx_slot ? 4'h0 : rx_cnt_r + 4'h1;
      rx_prev_r <= rx_line;
      if (!on_ref)
        rx_shift_r <= {rx_line ^ rx_prev_r, rx_shift_r[23:1]};
      // a port swap ends framing, a same-cycle hit wins
      if (port_select != rx_sel_r || loopback_control != rx_lb_r)
        framed_r <= 1'b0;
      // move the boundary, leave the counter alone
      if (reframe_enable && !on_ref && sync_hit)
      begin
        align_r <= rx_cnt_r;
        framed_r <= 1'b1;
      end
      else if (align_r > len_m1)
        align_r <= 4'h0;
      // receive clock follows the character count in fifo bypass, held low otherwise
      receive_clock_r <= ~fifo_bypass_n & (rx_cnt_r < half_len);
      rx_word_valid_o <= rx_slot;
      if (rx_slot)
      begin
        // fault output moves only with the character clock
        fault_r <= ~link_ok;
        if (!encoder_bypass_n)
        begin
          rx_word_o <= rx_char;
          receive_command_data_flag_o <= 1'b0;
          violation_output_o <= 1'b0;
        end
        else
        begin
          rx_word_o <= {2'h0, dec_word};
          receive_command_data_flag_o <= dec_cmd;
          violation_output_o <= dec_bad;
        end
      end
    end
  end

  // previous source selection, to notice a port switch
  // held in registers declared with the others above
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rx_sel_r <= 1'b0;
      rx_lb_r <= 1'b0;
    end
    else
    begin
      rx_sel_r <= port_select;
      rx_lb_r <= loopback_control;
    end
  end

  assign link_fault_indicator_o = fault_r;
  assign receive_clock_o = receive_clock_r;

endmodule // slt_link_core

`default_nettype wire

// >>> dv/slt_remote_model.sv
// far transceiver: sync fill on port a, a silent link on port b
// assumes one serial bit per core clock and narrow characters
`timescale 1ns/10ps
`default_nettype none
`include "slt_link_regs.vh"
module slt_remote_model (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic port_a_o,
  output logic port_b_o
);
  localparam logic [9:0] FILL = `SLT_SYNC_SHORT;
  logic [3:0] pos_r;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_r <= 4'h0;
      port_a_o <= 1'b0;
    end
    else
    begin
      port_a_o <= port_a_o ^ FILL[pos_r];
      pos_r <= (pos_r == 4'h9) ? 4'h0 : pos_r + 4'h1;
    end
  end
  // no transitions on the idle link
  assign port_b_o = 1'b0;
endmodule // slt_remote_model
`default_nettype wire

// >>> dv/slt_link_props.sv
// concurrent checks on the link core ports
// assumes control is written only over the wishbone port
`timescale 1ns/10ps
`default_nettype none
`include "slt_link_regs.vh"
module slt_link_props (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic transmit_halt_i,
  input wire logic transmit_word_enable_i,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_fifo_read_o,
  input wire logic serial_out_o,
  input wire logic amplitude_ok_i,
  input wire logic transition_ok_i,
  input wire logic freq_in_range_i,
  input wire logic carrier_detect_i,
  input wire logic link_fault_indicator_o,
  input wire logic receive_clock_o,
  input wire logic rx_word_valid_o
);
  logic [7:0] ctrl_r;
  logic [3:0] ok_r;
  logic [5:0] st_r;
  logic [4:0] fill_r;
  logic [4:0] age_r;
  logic wr;
  logic fill;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0]
    & (wb_adr_i == 8'h00);
  assign fill = ~ctrl_r[2] & ~ctrl_r[3] & ctrl_r[4] & ~transmit_word_enable_i;
  // shadow control and saturating age counters
  always @(posedge core_clk_i)
  begin
    ok_r <= {amplitude_ok_i, transition_ok_i, freq_in_range_i,
      carrier_detect_i};
    if (reset_i || ok_r != {amplitude_ok_i, transition_ok_i,
        freq_in_range_i, carrier_detect_i})
      st_r <= 6'h0;
    else if (st_r != 6'h3f)
      st_r <= st_r + 6'h1;
    if (reset_i)
      ctrl_r <= `SLT_CTRL_RESET;
    else if (wr)
      ctrl_r <= wb_dat_i[7:0];
    if (reset_i || wr)
      age_r <= 5'h0;
    else if (age_r != 5'h1f)
      age_r <= age_r + 5'h1;
    if (reset_i || !fill)
      fill_r <= 5'h0;
    else if (fill_r != 5'h1f)
      fill_r <= fill_r + 5'h1;
  end
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one cycle");
  property p_fault;
    st_r == 6'h3f |-> link_fault_indicator_o == !(&ok_r);
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag wrong");
  property p_range;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h04
      |-> wb_dat_o[3] == (ctrl_r[1] && (ctrl_r[0] || ctrl_r[2]));
  endproperty
  a_range: assert property (p_range) else $error("range not forced");
  property p_read_ok;
    tx_fifo_read_o |-> ctrl_r[2] && !tx_fifo_empty_i;
  endproperty
  a_read_ok: assert property (p_read_ok) else $error("bad fifo read");
  property p_halt;
    ctrl_r[2] && transmit_halt_i |-> !tx_fifo_read_o;
  endproperty
  a_halt: assert property (p_halt) else $error("read while halted");
  property p_rck_off;
    ctrl_r[2] && $past(ctrl_r[2]) |-> !receive_clock_o;
  endproperty
  a_rck_off: assert property (p_rck_off) else $error("rx clock out");
  property p_rck_period;
    $rose(receive_clock_o) && age_r == 5'h1f && !ctrl_r[2] && ctrl_r[4]
      |-> $past(receive_clock_o, 10) && !$past(receive_clock_o, 11);
  endproperty
  a_rck_period: assert property (p_rck_period) else $error("rx period");
  property p_slot_gap;
    rx_word_valid_o |=> !rx_word_valid_o [*8];
  endproperty
  a_slot_gap: assert property (p_slot_gap) else $error("slot hop");
  property p_fill;
    fill_r == 5'h1f |-> serial_out_o == $past(serial_out_o, 10);
  endproperty
  a_fill: assert property (p_fill) else $error("fill not periodic");
endmodule // slt_link_props
bind slt_link_core slt_link_props u_props (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .transmit_halt_i(transmit_halt_i),
  .transmit_word_enable_i(transmit_word_enable_i),
  .tx_fifo_empty_i(tx_fifo_empty_i), .tx_fifo_read_o(tx_fifo_read_o),
  .serial_out_o(serial_out_o), .amplitude_ok_i(amplitude_ok_i),
  .transition_ok_i(transition_ok_i), .freq_in_range_i(freq_in_range_i),
  .carrier_detect_i(carrier_detect_i),
  .link_fault_indicator_o(link_fault_indicator_o),
  .receive_clock_o(receive_clock_o), .rx_word_valid_o(rx_word_valid_o));
`default_nettype wire

// >>> dv/slt_link_core_tb.sv
// self-checking bench for the serial link core
// assumes the remote model on the ports and a bench-held tx fifo
`timescale 1ns/10ps
`default_nettype none
module slt_link_core_tb;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic halt = 1'b0;
  logic en = 1'b0;
  logic full = 1'b0;
  logic empty = 1'b1;
  logic [11:0] word = 12'h0;
  logic [3:0] ok = 4'hf;
  logic [31:0] seed = 32'h17fd0;
  logic [31:0] r;
  logic [63:0] e;
  logic [63:0] exp_q[$];
  wire [31:0] rdat;
  wire [11:0] rxw;
  wire ack, rd, sout, pa, pb, fault, rck, rxv, rxc, vio;
  int n_errors = 0;
  int num_checks = 0;
  int n_rd = 0;
  int a0;
  int i;
  slt_link_core u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .transmit_halt_i(halt), .transmit_word_bus_i(word),
    .transmit_word_enable_i(en), .transmit_fifo_full_flag_i(full),
    .tx_fifo_empty_i(empty), .tx_fifo_word_i(word), .tx_fifo_read_o(rd),
    .serial_out_o(sout), .serial_input_port_a_i(pa),
    .serial_input_port_b_i(pb), .amplitude_ok_i(ok[3]),
    .transition_ok_i(ok[2]), .freq_in_range_i(ok[1]),
    .carrier_detect_i(ok[0]), .link_fault_indicator_o(fault),
    .receive_clock_o(rck), .rx_word_o(rxw), .rx_word_valid_o(rxv),
    .receive_command_data_flag_o(rxc), .violation_output_o(vio));
  slt_remote_model u_far (.clk_i(core_clk_i), .rst_i(reset_i),
    .port_a_o(pa), .port_b_o(pb));
  // bench clock
  initial
  begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is seen
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge core_clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x);
    exp_q.push_back({m, x});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // read monitor takes the oldest note
  always @(posedge core_clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
    begin
      e = exp_q.pop_front();
      check(rdat & e[63:32], e[31:0]);
    end
  end
  // fifo reads counted off the clock edge
  always @(negedge core_clk_i)
  begin
    if (rd === 1'b1)
      n_rd++;
  end
  initial
  begin
    waitc(20000);
    n_errors++;
    end_sim();
  end
  initial
  begin
    waitc(5);
    reset_i <= 1'b0;
    waitc(1);
    rdx(8'h00, 32'hffffffff, 32'h9c);
    bus(1'b1, 8'h40, 32'hff);
    rdx(8'h40, 32'hffffffff, 32'h0);
    rdx(8'h00, 32'hffffffff, 32'h9c);
    $display("test registers done");
    repeat (6)
    begin
      r = rnd();
      ok <= r[3:0];
      waitc(80);
      rdx(8'h04, 32'h3b, {26'h0, 2'h1, 2'h0, ~r[1], ~&r[3:0]});
    end
    ok <= 4'hf;
    $display("test link fault done");
    empty <= 1'b0;
    halt <= 1'b1;
    waitc(3);
    a0 = n_rd;
    waitc(60);
    check(32'(n_rd - a0), 32'h0);
    halt <= 1'b0;
    waitc(15);
    a0 = n_rd;
    waitc(60);
    check(32'(n_rd - a0), 32'h6);
    $display("test fifo halt done");
    bus(1'b1, 8'h00, 32'hb2);
    waitc(200);
    rdx(8'h04, 32'h3c, 32'h14);
    rdx(8'h08, 32'h3ff, 32'h238);
    halt <= 1'b1;
    en <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      // reframe off keeps the found boundary
      bus(1'b1, 8'h00, i ? 32'h3a : 32'h32);
      repeat (3)
      begin
        r = rnd();
        word <= r[11:0];
        full <= 1'b0;
        waitc(100);
        rdx(8'h08, i ? 32'h30ff : 32'h3ff, i ? {24'h0, r[7:0]} : r[9:0]);
        full <= 1'b1;
        waitc(100);
        rdx(8'h08, i ? 32'h3000 : 32'h3ff, i ? 32'h1000 : 32'h238);
      end
    end
    $display("test transmit loop done");
    en <= 1'b0;
    full <= 1'b0;
    bus(1'b1, 8'h00, 32'h92);
    waitc(200);
    rdx(8'h08, 32'h3ff, 32'h238);
    bus(1'b1, 8'h00, 32'hd9);
    waitc(200);
    // silent port b decodes as an invalid symbol
    rdx(8'h08, 32'h33ff, 32'h2000);
    rdx(8'h04, 32'h3b, 32'h20);
    check({17'h0, fault, vio, rxc, rxw}, 32'h2000);
    $display("test port select done");
    waitc(2);
    end_sim();
  end
endmodule // slt_link_core_tb
`default_nettype wire
